/* File: inc/spio_pkg.sv */
// Shared-pin I/O port constants and register map
package spio_pkg;
	localparam int          PORT_W     = 16;
	localparam int          ADDR_W     = 12;
	localparam int          SEL_W      = 5;
	localparam int          NFUNC      = 32;
	// Register byte offsets
	localparam logic [11:0] OFF_DIR    = 12'h000;
	localparam logic [11:0] OFF_LAT    = 12'h004;
	localparam logic [11:0] OFF_PORT   = 12'h008;
	localparam logic [11:0] OFF_REMAP  = 12'h00C;
	// Pins bonded out on this variant
	localparam logic [15:0] IMPL_MASK  = 16'h3FFF;
	// Pins whose sharing peripheral can drive an output
	localparam logic [15:0] POUT_MASK  = 16'h0F0F;
	// Remappable pin positions
	localparam int          UPPER_PIN  = 13;
	localparam int          LOWER_PIN  = 12;
	// Remap register field layout
	localparam int          UPPER_LSB  = 8;
	localparam int          LOWER_LSB  = 0;
	// Reset values and the no-function remap select code
	localparam logic [15:0] DIR_RST    = 16'hFFFF;
	localparam logic [15:0] LAT_RST    = 16'h0000;
	localparam logic [4:0]  SEL_RST    = 5'h00;
	localparam logic [4:0]  SEL_NONE   = 5'h00;
endpackage

/* File: verilog/spio_port.sv */
// Shared-pin parallel I/O port with APB registers and remap output select
// Contract
// - Each shared pin is driven by either its peripheral or the port, never both.
// - The port's own output value never reaches the input of a sharing peripheral.
// - An enabled, actively driving peripheral disables the port driver but the pin stays readable.
// - An enabled peripheral that is not driving leaves the pin to the port.
// - Direction bit one makes the pin an input, zero makes it a port output.
// - Reset sets every implemented direction bit so all pins are inputs.
// - The latch register reads back the latch and writes only the latch.
// - The pin-state register reads pin levels and writes go to the latch.
// - Unimplemented bits are disabled and read zero in latch, direction and pin state.
// - A pin shared only with input functions acts as a dedicated port pin.
// - Remap bits 12 to 8 select the peripheral output routed to the upper remappable pin.
// - Remap bits 4 to 0 select the peripheral output routed to the lower remappable pin.
// - Remap bits 15 to 13 and 7 to 5 ignore writes and read zero.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module spio_port (
	input  wire logic                         ref_clk,
	input  wire logic                         sys_rst,
	input  wire logic [spio_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [spio_pkg::PORT_W-1:0]  pin_in,
	output logic      [spio_pkg::PORT_W-1:0]  pin_out,
	output logic      [spio_pkg::PORT_W-1:0]  pin_oe_n,
	input  wire logic [spio_pkg::PORT_W-1:0]  periph_en,
	input  wire logic [spio_pkg::PORT_W-1:0]  periph_drive,
	input  wire logic [spio_pkg::PORT_W-1:0]  periph_out,
	output logic      [spio_pkg::PORT_W-1:0]  periph_in,
	input  wire logic [spio_pkg::NFUNC-1:0]   remap_func_out
);
	import spio_pkg::*;

	typedef struct packed {
		logic [PORT_W-1:0] dir;
		logic [PORT_W-1:0] lat;
		logic [PORT_W-1:0] sync1;
		logic [PORT_W-1:0] sync2;
		logic [SEL_W-1:0]  upper_remap_func_sel;
		logic [SEL_W-1:0]  lower_remap_func_sel;
		logic [PORT_W-1:0] pin_out;
		logic [PORT_W-1:0] pin_oe_n;
		logic [PORT_W-1:0] periph_in;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
	} spio_state_s;

	spio_state_s s;
	spio_state_s next_s;

	logic [PORT_W-1:0] own;
	logic [PORT_W-1:0] own_data;
	logic [PORT_W-1:0] port_drv;
	logic [PORT_W-1:0] pin_state_reg;
	logic [31:0]       remap_rd;
	logic              access;
	logic              done;
	logic              hit;
	logic [31:0]       rd_mux;

	assign access = psel && penable;
	assign done   = access && s.pready;

	// Pin state seen by software, unbonded bits forced low
	// unbonded read zero
	assign pin_state_reg = s.sync2 & IMPL_MASK;

	assign remap_rd = {16'h0000, 3'h0, s.upper_remap_func_sel, 3'h0, s.lower_remap_func_sel};

	// Per-pin ownership and output data select
	genvar i;
	generate
		for (i = 0; i < PORT_W; i++) begin : g_pin
			always_comb begin
				if (i == UPPER_PIN && s.upper_remap_func_sel != SEL_NONE) begin
					own[i]      = IMPL_MASK[i];
					own_data[i] = remap_func_out[s.upper_remap_func_sel];
				end else if (i == LOWER_PIN && s.lower_remap_func_sel != SEL_NONE) begin
					own[i]      = IMPL_MASK[i];
					own_data[i] = remap_func_out[s.lower_remap_func_sel];
				end else begin
					own[i]      = IMPL_MASK[i] & POUT_MASK[i] & periph_en[i] & periph_drive[i];
					own_data[i] = periph_out[i];
				end
				port_drv[i] = IMPL_MASK[i] & ~own[i] & ~s.dir[i];
			end
		end
	endgenerate

	// Register read select
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFF_DIR:   rd_mux = {16'h0000, s.dir & IMPL_MASK};
			OFF_LAT:   rd_mux = {16'h0000, s.lat & IMPL_MASK};
			OFF_PORT:  rd_mux = {16'h0000, pin_state_reg};
			OFF_REMAP: rd_mux = remap_rd;
			default:   hit = 1'b0;
		endcase
	end

	always_comb begin
		next_s = s;

		next_s.sync1 = pin_in;
		next_s.sync2 = s.sync1;

		// One wait state, answer on second access edge
		next_s.pready = access && !s.pready;
		if (access && !s.pready) begin
			next_s.prdata  = (pwrite || !hit) ? 32'h0000_0000 : rd_mux;
			next_s.pslverr = !hit;
		end

		if (done && pwrite) begin
			unique case (paddr)
				OFF_DIR:  next_s.dir = pwdata[15:0] & IMPL_MASK;
				OFF_LAT,
				OFF_PORT: next_s.lat = pwdata[15:0] & IMPL_MASK;
				OFF_REMAP: begin
					next_s.upper_remap_func_sel = pwdata[UPPER_LSB +: SEL_W];
					next_s.lower_remap_func_sel = pwdata[LOWER_LSB +: SEL_W];
				end
				default: ;
			endcase
		end

		next_s.pin_out  = ((own & own_data) | (port_drv & s.lat)) & IMPL_MASK;
		next_s.pin_oe_n = ~(own | port_drv);

		next_s.periph_in = s.sync2 & IMPL_MASK & ~port_drv;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s.dir                  <= DIR_RST & IMPL_MASK;
			s.lat                  <= LAT_RST;
			s.sync1                <= 16'h0000;
			s.sync2                <= 16'h0000;
			s.upper_remap_func_sel <= SEL_RST;
			s.lower_remap_func_sel <= SEL_RST;
			s.pin_out              <= 16'h0000;
			s.pin_oe_n             <= 16'hFFFF;
			s.periph_in            <= 16'h0000;
			s.prdata               <= 32'h0000_0000;
			s.pready               <= 1'b0;
			s.pslverr              <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata    = s.prdata;
	assign pready    = s.pready;
	assign pslverr   = s.pslverr;
	assign pin_out   = s.pin_out;
	assign pin_oe_n  = s.pin_oe_n;
	assign periph_in = s.periph_in;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	property p_one_driver;
		((own & port_drv) == 16'h0000) ##1 (pin_oe_n == ~($past(own) | $past(port_drv)));
	endproperty
	a_one_driver: assert property (p_one_driver) else $error("pin owned by both sources");

	property p_no_loop;
		(periph_in & $past(port_drv)) == 16'h0000;
	endproperty
	a_no_loop: assert property (p_no_loop) else $error("port output looped into peripheral");

	property p_periph_owns;
		(own[0] && !sys_rst) |=> (!pin_oe_n[0] && pin_out[0] == $past(periph_out[0]));
	endproperty
	a_periph_owns: assert property (p_periph_owns) else $error("peripheral drive not honoured");

	property p_port_back;
		(periph_en[0] && !periph_drive[0] && !s.dir[0]) |=> (pin_out[0] == $past(s.lat[0]));
	endproperty
	a_port_back: assert property (p_port_back) else $error("idle peripheral blocked port");

	property p_dir_input;
		(s.dir[1] && !own[1]) |=> pin_oe_n[1];
	endproperty
	a_dir_input: assert property (p_dir_input) else $error("input pin was driven");

	property p_reset_in;
		@(posedge ref_clk) sys_rst |=> (s.dir == IMPL_MASK && pin_oe_n == 16'hFFFF);
	endproperty
	a_reset_in: assert property (p_reset_in) else $error("pins not inputs after reset");

	property p_lat_write;
		(done && pwrite && (paddr == OFF_LAT || paddr == OFF_PORT))
			|=> (s.lat == ($past(pwdata[15:0]) & IMPL_MASK));
	endproperty
	a_lat_write: assert property (p_lat_write) else $error("latch write lost");

	property p_port_read;
		(access && !s.pready && !pwrite && paddr == OFF_PORT)
			|=> (prdata[15:0] == ($past(pin_in, 3) & IMPL_MASK));
	endproperty
	a_port_read: assert property (p_port_read) else $error("pin read not synchronised");

	property p_unbonded;
		((s.dir | s.lat | pin_state_reg) & ~IMPL_MASK) == 16'h0000 && (pin_oe_n & ~IMPL_MASK) == ~IMPL_MASK;
	endproperty
	a_unbonded: assert property (p_unbonded) else $error("unbonded bit active");

	property p_upper_remap;
		(s.upper_remap_func_sel != SEL_NONE)
			|=> (pin_out[UPPER_PIN] == $past(remap_func_out[s.upper_remap_func_sel]));
	endproperty
	a_upper_remap: assert property (p_upper_remap) else $error("upper remap wrong");

	property p_lower_remap;
		(s.lower_remap_func_sel != SEL_NONE)
			|=> (pin_out[LOWER_PIN] == $past(remap_func_out[s.lower_remap_func_sel]));
	endproperty
	a_lower_remap: assert property (p_lower_remap) else $error("lower remap wrong");

	property p_remap_rsv;
		(access && !s.pready && !pwrite && paddr == OFF_REMAP) |=> (prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0);
	endproperty
	a_remap_rsv: assert property (p_remap_rsv) else $error("reserved remap bits set");

	property p_sel_reset;
		@(posedge ref_clk) sys_rst |=> (s.upper_remap_func_sel == SEL_RST && s.lower_remap_func_sel == SEL_RST);
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("selectors not cleared");

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");

	// Bus timing, register map and pin ownership
	property p_ready_wait;
		(access && !pready) |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("access not answered after one wait");

	property p_ready_idle;
		!psel |=> !pready;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("pready without a transfer");

	property p_err_zero;
		(pready && pslverr) |-> (prdata == 32'h0000_0000);
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("unmapped read returned data");

	property p_bad_write;
		(done && pwrite && !hit)
			|=> ($stable(s.dir) && $stable(s.lat) && $stable(s.upper_remap_func_sel));
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("unmapped write changed state");

	property p_dir_write;
		(done && pwrite && paddr == OFF_DIR) |=> (s.dir == ($past(pwdata[15:0]) & IMPL_MASK));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");

	property p_dir_read;
		(access && !s.pready && !pwrite && paddr == OFF_DIR)
			|=> (prdata == {16'h0000, $past(s.dir)});
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

	property p_lat_read;
		(access && !s.pready && !pwrite && paddr == OFF_LAT)
			|=> (prdata == {16'h0000, $past(s.lat)});
	endproperty
	a_lat_read: assert property (p_lat_read) else $error("latch read wrong");

	property p_lat_only;
		(done && pwrite && paddr == OFF_LAT) |=> $stable(s.dir);
	endproperty
	a_lat_only: assert property (p_lat_only) else $error("latch write touched direction");

	property p_port_no_store;
		(done && pwrite && paddr == OFF_PORT) |=> $stable(s.dir);
	endproperty
	a_port_no_store: assert property (p_port_no_store) else $error("port write touched direction");

	property p_remap_write;
		(done && pwrite && paddr == OFF_REMAP)
			|=> (s.upper_remap_func_sel == $past(pwdata[UPPER_LSB +: SEL_W])
				&& s.lower_remap_func_sel == $past(pwdata[LOWER_LSB +: SEL_W]));
	endproperty
	a_remap_write: assert property (p_remap_write) else $error("remap write lost");

	property p_unbonded_out;
		(pin_out & ~IMPL_MASK) == 16'h0000;
	endproperty
	a_unbonded_out: assert property (p_unbonded_out) else $error("unbonded pin data set");

	property p_periph_read;
		own[0] |=> (periph_in[0] == $past(s.sync2[0]));
	endproperty
	a_periph_read: assert property (p_periph_read) else $error("driven pin not readable");

	property p_dedicated;
		(periph_en[4] && periph_drive[4] && !s.dir[4]) |=> (pin_out[4] == $past(s.lat[4]));
	endproperty
	a_dedicated: assert property (p_dedicated) else $error("input-only pin lost to peripheral");

	property p_upper_oe;
		(s.upper_remap_func_sel != SEL_NONE) |=> !pin_oe_n[UPPER_PIN];
	endproperty
	a_upper_oe: assert property (p_upper_oe) else $error("upper remap pin not driven");

	property p_lower_oe;
		(s.lower_remap_func_sel != SEL_NONE) |=> !pin_oe_n[LOWER_PIN];
	endproperty
	a_lower_oe: assert property (p_lower_oe) else $error("lower remap pin not driven");

	property p_upper_none;
		(s.upper_remap_func_sel == SEL_NONE && s.dir[UPPER_PIN]) |=> pin_oe_n[UPPER_PIN];
	endproperty
	a_upper_none: assert property (p_upper_none) else $error("upper pin driven with no function");

	property p_lower_none;
		(s.lower_remap_func_sel == SEL_NONE && s.dir[LOWER_PIN]) |=> pin_oe_n[LOWER_PIN];
	endproperty
	a_lower_none: assert property (p_lower_none) else $error("lower pin driven with no function");

	c_write_lat:   cover property (done && pwrite && paddr == OFF_LAT);
	c_periph_own:  cover property (own[0] ##1 !own[0]);
	c_remap_upper: cover property (s.upper_remap_func_sel != SEL_NONE);
	c_bad_addr:    cover property (pready && pslverr);
	c_remap_lower: cover property (s.lower_remap_func_sel != SEL_NONE);
endmodule

/* File: tb/spio_far.sv */
// Pin pad model: block drive against an outside source
`timescale 1ns/10ps
module spio_far (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] ext_level,
	output logic      [15:0] pin_in
);
	// Driven pins show the block value, released pins the outside level
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

/* File: tb/spio_port_test.sv */
// Self-checking bench for the shared-pin port
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module spio_port_test;
	import spio_pkg::*;
	logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, d;
	logic        pready, pslverr, e;
	logic [15:0] pin_in, pin_out, pin_oe_n, periph_in, ext = 0;
	logic [15:0] p_en = 0, p_drv = 0, p_out = 0;
	logic [31:0] rfo = 0;
	int          n_mismatch = 0, total_checks = 0;
	spio_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .periph_en(p_en), .periph_drive(p_drv),
		.periph_out(p_out), .periph_in(periph_in), .remap_func_out(rfo));
	spio_far far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
		int i;
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk);
		if (i == 20) begin
			n_mismatch++;
			conclude();
		end
		d = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task t_reset;
		xfer(OFF_DIR, 0, 0);   `CHK("dir", 32'h3FFF, d)
		xfer(OFF_LAT, 0, 0);   `CHK("lat", 32'h0, d)
		xfer(OFF_REMAP, 0, 0); `CHK("remap", 32'h0, d)
		`CHK("oe_n", 16'hFFFF, pin_oe_n)
	endtask
	task t_output;
		xfer(OFF_DIR, 1, 0); xfer(OFF_LAT, 1, 32'hA5A5);
		xfer(OFF_LAT, 0, 0); `CHK("lat", 32'h25A5, d)
		wt(4);
		`CHK("pin_out", 16'h25A5, pin_out)
		`CHK("oe_n", 16'hC000, pin_oe_n)
		xfer(OFF_PORT, 0, 0); `CHK("port", 32'h25A5, d)
		`CHK("periph_in", 16'h0, periph_in)
		xfer(OFF_PORT, 1, 32'h1234);
		xfer(OFF_LAT, 0, 0); `CHK("lat", 32'h1234, d)
	endtask
	task t_periph;
		p_en <= 16'hFFFF; p_drv <= 16'hFFFF; p_out <= 16'h00FF;
		wt(3);
		`CHK("pin_out", 16'h103F, pin_out)
		xfer(OFF_PORT, 0, 0); `CHK("port", 32'h103F, d)
		p_drv <= 0;
		wt(3);
		`CHK("pin_out", 16'h1234, pin_out)
		p_en <= 0; p_out <= 0;
	endtask
	task t_input;
		xfer(OFF_DIR, 1, 32'hFFFF);
		ext <= 16'h5A5A;
		wt(4);
		`CHK("oe_n", 16'hFFFF, pin_oe_n)
		xfer(OFF_PORT, 0, 0); `CHK("port", 32'h1A5A, d)
		`CHK("periph_in", 16'h1A5A, periph_in)
	endtask
	task t_remap;
		xfer(OFF_REMAP, 1, 32'hFFFF);
		xfer(OFF_REMAP, 0, 0); `CHK("remap", 32'h1F1F, d)
		xfer(OFF_REMAP, 1, 32'h0305);
		rfo <= 32'h8;
		wt(3);
		`CHK("oe_n", 16'hCFFF, pin_oe_n)
		`CHK("remap_pins", 2'b10, pin_out[13:12])
		xfer(OFF_REMAP, 1, 0);
		wt(3);
		`CHK("oe_n", 16'hFFFF, pin_oe_n)
	endtask
	task t_unmapped;
		xfer(12'h010, 1, 32'hFFFF); `CHK("err", 1'b1, e)
		xfer(12'h010, 0, 0); `CHK("rd", 32'h0, d)
		`CHK("err", 1'b1, e)
	endtask
	initial begin
		wt(6);
		sys_rst <= 0;
		t_reset(); t_output(); t_periph(); t_input(); t_remap(); t_unmapped();
		conclude();
	end
endmodule
